// file: odd_orientation.sv
/*
 * orientation detect and debounce: configuration/threshold registers, the
 * portrait/landscape decision with hysteresis, the debounce counter and the
 * orientation status with its change flag.
 * assumes angle inputs, sample_tick and the register strobes come from logic
 * on the same clock; the serial register engine sits outside this block.
 */
`timescale 1ns/1ns
module odd_orientation
	import odd_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// register access from the serial engine
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// sample stream and operating state
	input wire logic sample_tick,
	input wire logic active,
	input wire logic sleep_state,
	input wire logic [2:0] output_sample_rate,
	input wire logic [1:0] os_mode,
	// angle data per sample
	input wire logic [6:0] pl_angle_deg,
	input wire logic portrait_neg,
	input wire logic landscape_neg,
	input wire logic [6:0] z_tilt_deg,
	input wire logic back_beyond_trip,
	input wire logic over_limit,
	// status
	output logic [1:0] orientation_result,
	output logic back_front_result,
	output logic z_tilt_hold_flag,
	output logic orientation_change_flag
);
	logic debounce_counter_mode_reg, orientation_detect_enable_reg;
	logic [7:0] debounce_count_value_reg, rdata_reg;
	logic [8:0] deb_cnt_reg, deb_cnt_next, weight;
	logic [3:0] cand_reg, cand, reported;
	logic [1:0] orient_reg, cand_orient;
	logic first_reg, sleep_d_reg, bf_reg, lo_reg, flag_reg;
	logic [9:0] cnt_sum;
	logic cand_lo, run, eval, adopt, wake_edge, status_read;
	// samples weighted in time steps: weight = sample period / step, as a shift
	function automatic logic [3:0] odd_step_log2(input logic [2:0] rate, input logic [1:0] mode);
		logic [3:0] s;
		case (rate)
			ODD_RATE_800: s = 4'h0;
			ODD_RATE_400: s = 4'h1;
			ODD_RATE_200: s = 4'h2;
			ODD_RATE_100: s = 4'h3;
			ODD_RATE_50: s = 4'h4;
			ODD_RATE_12P5: s = (mode == ODD_OS_NORMAL) ? 4'h4 : 4'h6;
			default: s = (mode == ODD_OS_NORMAL) ? 4'h4 :
				(mode == ODD_OS_LOW_POWER) ? 4'h7 : 4'h6;
		endcase
		if (mode == ODD_OS_HIGH_RES && rate != ODD_RATE_800)
			s = 4'h1;
		return s;
	endfunction : odd_step_log2
	function automatic logic [3:0] odd_period_log2(input logic [2:0] rate);
		logic [3:0] p;
		case (rate)
			ODD_RATE_800: p = 4'h0;
			ODD_RATE_400: p = 4'h1;
			ODD_RATE_200: p = 4'h2;
			ODD_RATE_100: p = 4'h3;
			ODD_RATE_50: p = 4'h4;
			ODD_RATE_12P5: p = 4'h6;
			ODD_RATE_6P25: p = 4'h7;
			default: p = 4'h9;
		endcase
		return p;
	endfunction : odd_period_log2
	assign weight = 9'h001 << (odd_period_log2(output_sample_rate) -
		odd_step_log2(output_sample_rate, os_mode));
	assign run = orientation_detect_enable_reg && active;
	assign eval = run && sample_tick && !over_limit;
	assign wake_edge = sleep_state != sleep_d_reg;
	assign status_read = reg_rd && reg_addr == ODD_STATUS_ADDR;
	////////////////////////////////////////////////////////////////////////
	// candidate orientation
	// hysteresis: the trip depends on the side currently reported
	always_comb
	begin
		if (orient_reg[1])
			cand_orient = (pl_angle_deg >= ODD_TRIP_TO_PORTRAIT) ?
				{1'b0, portrait_neg} : {1'b1, landscape_neg};
		else
			cand_orient = (pl_angle_deg <= ODD_TRIP_TO_LANDSCAPE) ?
				{1'b1, landscape_neg} : {1'b0, portrait_neg};
	end
	assign cand_lo = z_tilt_deg > ODD_Z_TILT_HOLD_ANGLE_DEG;
	// under tilt hold only the hold flag may move
	assign cand = cand_lo ? {1'b1, bf_reg, orient_reg} :
		{1'b0, back_beyond_trip, cand_orient};
	assign reported = {lo_reg, bf_reg, orient_reg};
	////////////////////////////////////////////////////////////////////////
	// debounce counter
	assign cnt_sum = {1'b0, deb_cnt_reg} + {1'b0, weight};
	assign adopt = eval && cand != reported &&
		(first_reg || cnt_sum >= {2'h0, debounce_count_value_reg});
	always_comb
	begin
		deb_cnt_next = deb_cnt_reg;
		if (!run || wake_edge)
			deb_cnt_next = 9'h000;
		else if (eval)
		begin
			if (adopt)
				deb_cnt_next = 9'h000;
			else if (cand != reported && cand == cand_reg)
				deb_cnt_next = cnt_sum[9] ? 9'h1FF : cnt_sum[8:0];
			else if (cand != reported)
				deb_cnt_next = weight;
			else if (debounce_counter_mode_reg)
				deb_cnt_next = 9'h000;
			else
				deb_cnt_next = (deb_cnt_reg > weight) ? 9'(deb_cnt_reg - weight) : 9'h000;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			deb_cnt_reg <= 9'h000;
			cand_reg <= 4'h0;
			sleep_d_reg <= 1'b0;
		end
		else
		begin
			deb_cnt_reg <= deb_cnt_next;
			sleep_d_reg <= sleep_state;
			// keep the pending candidate across dips so decrement mode resumes
			if (eval && cand != reported)
				cand_reg <= cand;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// reported orientation and change flag
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			orient_reg <= ODD_PORTRAIT_UP;
			bf_reg <= 1'b0;
			lo_reg <= 1'b0;
			first_reg <= 1'b1;
		end
		else if (!run)
			first_reg <= 1'b1;
		else if (eval)
		begin
			first_reg <= 1'b0;
			if (adopt)
			begin
				lo_reg <= cand[3];
				bf_reg <= cand[2];
				orient_reg <= cand[1:0];
			end
		end
	end

	// a set in the same cycle as a status read wins over the clear
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			flag_reg <= 1'b0;
		else if (eval && (first_reg || adopt))
			flag_reg <= 1'b1;
		else if (status_read)
			flag_reg <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			debounce_counter_mode_reg <= ODD_MODE_RST;
			orientation_detect_enable_reg <= ODD_EN_RST;
			debounce_count_value_reg <= ODD_COUNT_RST;
		end
		else if (reg_wr)
		begin
			if (reg_addr == ODD_CFG_ADDR)
			begin
				debounce_counter_mode_reg <= reg_wdata[ODD_CFG_MODE_BIT];
				orientation_detect_enable_reg <= reg_wdata[ODD_CFG_EN_BIT];
			end
			else if (reg_addr == ODD_COUNT_ADDR)
				debounce_count_value_reg <= reg_wdata;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			rdata_reg <= 8'h00;
		else if (reg_rd)
		begin
			if (reg_addr == ODD_STATUS_ADDR)
				rdata_reg <= {flag_reg, lo_reg, 3'h0, orient_reg, bf_reg};
			else if (reg_addr == ODD_CFG_ADDR)
				rdata_reg <= {debounce_counter_mode_reg, orientation_detect_enable_reg,
					6'h00};
			else if (reg_addr == ODD_COUNT_ADDR)
				rdata_reg <= debounce_count_value_reg;
			else if (reg_addr == ODD_BFZ_ADDR)
				rdata_reg <= {ODD_BACK_FRONT_TRIP_ANGLE_CODE, 3'h0, ODD_Z_TILT_HOLD_ANGLE_CODE};
			else if (reg_addr == ODD_THS_ADDR)
				rdata_reg <= {ODD_THS_CODE, ODD_HYS_CODE};
			else
				rdata_reg <= 8'h00;
		end
	end
	assign reg_rdata = rdata_reg;
	assign orientation_result = orient_reg;
	assign back_front_result = bf_reg;
	assign z_tilt_hold_flag = lo_reg;
	assign orientation_change_flag = flag_reg;
	////////////////////////////////////////////////////////////////////////
	// checks
	sequence s_hold_eval;
		eval && !first_reg && cand != reported && !adopt;
	endsequence
	clear_mode_a: assert property (@(posedge clk) disable iff (rst)
		run && !wake_edge && eval && cand == reported && debounce_counter_mode_reg
		|=> deb_cnt_reg == 9'h000)
		else $error("counter not cleared in clear mode");
	decrement_mode_a: assert property (@(posedge clk) disable iff (rst)
		run && !wake_edge && eval && cand == reported && !debounce_counter_mode_reg
		&& deb_cnt_reg > weight |=> deb_cnt_reg == $past(deb_cnt_reg) - $past(weight))
		else $error("counter not decremented");
	disabled_hold_a: assert property (@(posedge clk) disable iff (rst)
		!run |=> $stable(orient_reg) && $stable(bf_reg) && deb_cnt_reg == 9'h000)
		else $error("orientation moved while disabled");
	debounce_wait_a: assert property (@(posedge clk) disable iff (rst)
		eval && !first_reg && cand != reported && cnt_sum < {2'h0, debounce_count_value_reg}
		|=> $past(reported) == reported)
		else $error("result changed before debounce count");
	wake_reset_a: assert property (@(posedge clk) disable iff (rst)
		wake_edge |=> deb_cnt_reg == 9'h000)
		else $error("counter kept across wake/sleep change");
	step_weight_a: assert property (@(posedge clk) disable iff (rst)
		os_mode == ODD_OS_HIGH_RES && output_sample_rate == ODD_RATE_12P5
		|-> weight == 9'h020)
		else $error("wrong high resolution step weight");
	lp_weight_a: assert property (@(posedge clk) disable iff (rst)
		os_mode == ODD_OS_LOW_POWER && output_sample_rate == ODD_RATE_6P25
		|-> weight == 9'h001)
		else $error("wrong low power step weight");
	change_flag_a: assert property (@(posedge clk) disable iff (rst)
		adopt |=> flag_reg ##0 reported != $past(reported))
		else $error("change without flag");
	flag_clear_a: assert property (@(posedge clk) disable iff (rst)
		status_read && !(eval && (first_reg || adopt)) |=> !flag_reg ##1 $stable(flag_reg)
		|| eval || $past(eval))
		else $error("flag survived status read");
	overload_hold_a: assert property (@(posedge clk) disable iff (rst)
		over_limit |=> $stable(orient_reg) && $stable(lo_reg))
		else $error("orientation moved over limit");
	pending_hold_a: assert property (@(posedge clk) disable iff (rst)
		s_hold_eval |=> $stable(reported))
		else $error("pending orientation adopted early");
	fixed_read_a: assert property (@(posedge clk) disable iff (rst)
		reg_rd && reg_addr == ODD_THS_ADDR |=> reg_rdata == 8'h84)
		else $error("threshold register wrong");
	bfz_read_a: assert property (@(posedge clk) disable iff (rst)
		reg_rd && reg_addr == ODD_BFZ_ADDR |=> reg_rdata == 8'h44)
		else $error("back/front register wrong");
endmodule : odd_orientation

// file: odd_pkg.sv
/*
 * constants for the orientation detect and debounce block: register offsets,
 * field positions, reset values, fixed angle codes and rate/mode encodings.
 * assumes the register engine presents 8-bit addresses and 8-bit data.
 */
package odd_pkg;
	// register offsets
	localparam logic [7:0] ODD_STATUS_ADDR = 8'h10;
	localparam logic [7:0] ODD_CFG_ADDR = 8'h11;
	localparam logic [7:0] ODD_COUNT_ADDR = 8'h12;
	localparam logic [7:0] ODD_BFZ_ADDR = 8'h13;
	localparam logic [7:0] ODD_THS_ADDR = 8'h14;
	// field positions
	localparam int ODD_CFG_MODE_BIT = 7;
	localparam int ODD_CFG_EN_BIT = 6;
	// reset values
	localparam logic ODD_MODE_RST = 1'b1;
	localparam logic ODD_EN_RST = 1'b0;
	localparam logic [7:0] ODD_COUNT_RST = 8'h00;
	// fixed threshold codes
	localparam logic [1:0] ODD_BACK_FRONT_TRIP_ANGLE_CODE = 2'h1;
	localparam logic [2:0] ODD_Z_TILT_HOLD_ANGLE_CODE = 3'h4;
	localparam logic [4:0] ODD_THS_CODE = 5'h10;
	localparam logic [2:0] ODD_HYS_CODE = 3'h4;
	// fixed angles in degrees
	localparam logic [6:0] ODD_THS_DEG = 7'h2D;
	localparam logic [6:0] ODD_HYS_DEG = 7'h0E;
	localparam logic [6:0] ODD_Z_TILT_HOLD_ANGLE_DEG = 7'h1D;
	localparam logic [6:0] ODD_TRIP_TO_PORTRAIT = 7'(ODD_THS_DEG + ODD_HYS_DEG);
	localparam logic [6:0] ODD_TRIP_TO_LANDSCAPE = 7'(ODD_THS_DEG - ODD_HYS_DEG);
	// orientation result codes
	localparam logic [1:0] ODD_PORTRAIT_UP = 2'h0;
	localparam logic [1:0] ODD_PORTRAIT_DOWN = 2'h1;
	localparam logic [1:0] ODD_LANDSCAPE_RIGHT = 2'h2;
	localparam logic [1:0] ODD_LANDSCAPE_LEFT = 2'h3;
	// sample rate codes
	typedef enum logic [2:0] {
		ODD_RATE_800 = 3'h0,
		ODD_RATE_400 = 3'h1,
		ODD_RATE_200 = 3'h2,
		ODD_RATE_100 = 3'h3,
		ODD_RATE_50 = 3'h4,
		ODD_RATE_12P5 = 3'h5,
		ODD_RATE_6P25 = 3'h6,
		ODD_RATE_1P56 = 3'h7
	} odd_rate_e;
	// oversampling modes
	typedef enum logic [1:0] {
		ODD_OS_NORMAL = 2'h0,
		ODD_OS_LOW_NOISE = 2'h1,
		ODD_OS_HIGH_RES = 2'h2,
		ODD_OS_LOW_POWER = 2'h3
	} odd_os_e;
endpackage : odd_pkg

// file: odd_host_model.sv
/*
 * host-side register master standing in for the serial engine of the block.
 * assumes one clk shared with the block; strobes change only after rising edges.
 */
`timescale 1ns/1ns
module odd_host_model (
	// clock
	input wire logic clk,
	// strobes and data toward the block
	output logic [7:0] reg_addr,
	output logic reg_wr,
	output logic [7:0] reg_wdata,
	output logic reg_rd,
	// read return
	input wire logic [7:0] reg_rdata
);
	initial
	begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
		reg_rd = 1'b0;
	end
	////////////////////////////////////////
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		// released data is inverted so a stale value cannot pass for a write
		reg_wdata <= ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		#1;
		d = reg_rdata;
	endtask : rd
endmodule : odd_host_model

// file: tb_orientation_detect_debounce.sv
/*
 * self-checking testbench for the orientation detect and debounce block.
 * assumes the host model owns the register strobes; this bench drives samples.
 */
`timescale 1ns/1ns
module tb_orientation_detect_debounce
	import odd_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
	logic reg_wr, reg_rd, tk = 1'b0, slp = 1'b0, act = 1'b1;
	logic [2:0] rate = 3'h0;
	logic [1:0] os = 2'h0;
	logic [6:0] ang = 7'h46, zt = 7'h00;
	logic pn = 1'b0, ln = 1'b0, bk = 1'b0, ol = 1'b0;
	logic [1:0] res;
	logic bf, hold, flag;
	int error_cnt = 0;
	int total_checks = 0;
	odd_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	odd_orientation dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_tick(tk),
		.active(act), .sleep_state(slp), .output_sample_rate(rate), .os_mode(os),
		.pl_angle_deg(ang), .portrait_neg(pn), .landscape_neg(ln), .z_tilt_deg(zt),
		.back_beyond_trip(bk), .over_limit(ol), .orientation_result(res),
		.back_front_result(bf), .z_tilt_hold_flag(hold), .orientation_change_flag(flag));
	initial
	begin
		forever #5 clk = ~clk;
	end
	////////////////////////////////////////
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// status seen at the ports, without the clearing side effect of a read
	task automatic sp(input logic [7:0] exp);
		chk({flag, hold, 3'h0, res, bf}, exp);
	endtask : sp
	task automatic rs(input logic [7:0] a, input logic [7:0] exp);
		host.rd(a, rv);
		chk(rv, exp);
	endtask : rs
	task automatic tick(input int n);
		repeat (n)
		begin
			@(posedge clk);
			tk <= 1'b1;
			@(posedge clk);
			tk <= 1'b0;
		end
		repeat (2) @(posedge clk);
		#1;
	endtask : tick
	task automatic cand(input logic [6:0] a, input logic p, input logic l);
		@(posedge clk);
		ang <= a;
		pn <= p;
		ln <= l;
	endtask : cand
	task automatic done(input string s);
		$display("test %s done, mismatches so far %0d", s, error_cnt);
	endtask : done
	////////////////////////////////////////
	task automatic t_regs();
		rs(ODD_CFG_ADDR, 8'h80);
		rs(ODD_COUNT_ADDR, 8'h00);
		rs(ODD_BFZ_ADDR, 8'h44);
		rs(ODD_THS_ADDR, 8'h84);
		rs(8'h20, 8'h00);
		host.wr(ODD_BFZ_ADDR, 8'h00);
		host.wr(ODD_THS_ADDR, 8'h00);
		host.wr(ODD_CFG_ADDR, 8'hBF);
		host.wr(ODD_COUNT_ADDR, 8'hA5);
		rs(ODD_BFZ_ADDR, 8'h44);
		rs(ODD_THS_ADDR, 8'h84);
		rs(ODD_CFG_ADDR, 8'h80);
		rs(ODD_COUNT_ADDR, 8'hA5);
		done("registers");
	endtask : t_regs
	task automatic t_detect();
		cand(7'h14, 1'b0, 1'b1);
		tick(3);
		sp(8'h00);
		host.wr(ODD_COUNT_ADDR, 8'h02);
		host.wr(ODD_CFG_ADDR, 8'hC0);
		tick(1);
		sp(8'h86);
		rs(ODD_STATUS_ADDR, 8'h86);
		sp(8'h06);
		cand(7'h2D, 1'b0, 1'b1);
		tick(2);
		sp(8'h06);
		cand(7'h3B, 1'b0, 1'b0);
		tick(1);
		sp(8'h06);
		tick(1);
		sp(8'h80);
		rs(ODD_STATUS_ADDR, 8'h80);
		cand(7'h20, 1'b0, 1'b0);
		tick(2);
		sp(8'h00);
		cand(7'h1F, 1'b0, 1'b0);
		tick(2);
		rs(ODD_STATUS_ADDR, 8'h84);
		done("detect");
	endtask : t_detect
	task automatic t_mode();
		host.wr(ODD_COUNT_ADDR, 8'h03);
		cand(7'h46, 1'b1, 1'b0);
		tick(2);
		cand(7'h2D, 1'b0, 1'b0);
		tick(1);
		cand(7'h46, 1'b1, 1'b0);
		tick(2);
		sp(8'h04);
		tick(1);
		rs(ODD_STATUS_ADDR, 8'h82);
		host.wr(ODD_CFG_ADDR, 8'h40);
		cand(7'h14, 1'b1, 1'b1);
		tick(2);
		cand(7'h2D, 1'b1, 1'b0);
		tick(1);
		cand(7'h14, 1'b1, 1'b1);
		tick(1);
		sp(8'h02);
		tick(1);
		rs(ODD_STATUS_ADDR, 8'h86);
		// a sleep change mid-count must throw the partial count away
		cand(7'h46, 1'b0, 1'b0);
		tick(2);
		@(posedge clk);
		slp <= 1'b1;
		tick(2);
		sp(8'h06);
		tick(1);
		rs(ODD_STATUS_ADDR, 8'h80);
		@(posedge clk);
		slp <= 1'b0;
		done("counter mode and sleep");
	endtask : t_mode
	task automatic t_weight();
		// rate code, oversampling code and sample weight in time steps
		logic [2:0] rt[12] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h5, 3'h6, 3'h7, 3'h7, 3'h6, 3'h3, 3'h5};
		logic [1:0] om[12] = '{2'h0, 2'h2, 2'h2, 2'h2, 2'h0, 2'h1, 2'h3, 2'h3, 2'h1, 2'h0, 2'h3, 2'h2};
		logic [6:0] wt[12] = '{7'h01, 7'h01, 7'h02, 7'h08, 7'h04, 7'h01, 7'h01, 7'h04, 7'h08,
			7'h08, 7'h01, 7'h20};
		host.wr(ODD_CFG_ADDR, 8'hC0);
		for (int i = 0; i < 12; i++)
		begin
			host.wr(ODD_COUNT_ADDR, {wt[i], 1'b0});
			@(posedge clk);
			rate <= rt[i];
			os <= om[i];
			cand(7'h46, ~pn, 1'b0);
			tick(1);
			sp({6'h00, ~pn, 1'b0});
			tick(1);
			rs(ODD_STATUS_ADDR, {6'h20, pn, 1'b0});
		end
		done("time step weights");
	endtask : t_weight
	task automatic t_hold();
		host.wr(ODD_COUNT_ADDR, 8'h00);
		@(posedge clk);
		ol <= 1'b1;
		cand(7'h46, 1'b1, 1'b0);
		tick(2);
		sp(8'h00);
		@(posedge clk);
		ol <= 1'b0;
		tick(1);
		rs(ODD_STATUS_ADDR, 8'h82);
		@(posedge clk);
		zt <= 7'h1D;
		tick(1);
		sp(8'h02);
		@(posedge clk);
		zt <= 7'h1E;
		tick(1);
		rs(ODD_STATUS_ADDR, 8'hC2);
		cand(7'h46, 1'b0, 1'b0);
		tick(2);
		sp(8'h42);
		cand(7'h46, 1'b1, 1'b0);
		zt <= 7'h00;
		tick(1);
		rs(ODD_STATUS_ADDR, 8'h82);
		@(posedge clk);
		bk <= 1'b1;
		tick(1);
		sp(8'h83);
		host.wr(ODD_CFG_ADDR, 8'h80);
		cand(7'h14, 1'b0, 1'b1);
		tick(2);
		sp(8'h83);
		done("hold and disable");
	endtask : t_hold
	// standby holds off detection; the first sample after activation raises the flag
	task automatic t_standby();
		rs(ODD_STATUS_ADDR, 8'h83);
		@(posedge clk);
		act <= 1'b0;
		host.wr(ODD_CFG_ADDR, 8'hC0);
		cand(7'h46, 1'b1, 1'b0);
		tick(2);
		sp(8'h03);
		@(posedge clk);
		act <= 1'b1;
		tick(1);
		sp(8'h83);
		done("standby to active");
	endtask : t_standby
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : finish_test
	initial
	begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_detect();
		t_mode();
		t_weight();
		t_hold();
		t_standby();
		finish_test();
	end
endmodule : tb_orientation_detect_debounce
